// ===== rtl/sat_pkg.sv
// Shared constants, types and helpers for segment address translation
package sat_pkg;
    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int SEG_COUNT = 6;
    localparam int SEG_IDX_W = 3;
    localparam int SEL_W = 16;
    localparam int INDEX_W = 13;
    localparam int PTR_W = 48;
    localparam int ADDR_W = 32;
    localparam int TABLE_ENTRIES = 8192;
    localparam int TABLE_BYTES = 65536;
    localparam int DESC_SHIFT = 3;
    localparam int REAL_SHIFT = 4;
    localparam int REAL_ADDR_W = 20;
    localparam int PAGE_SHIFT = 12;
    localparam int PAGE_W = 20;
    localparam int TLB_IDX_W = 3;
    localparam int TLB_ENTRIES = 8;
    localparam int TLB_TAG_W = 17;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RPL_LSB = 0;
    localparam int TI_BIT = 2;
    localparam int INDEX_LSB = 3;
    localparam int PTR_BASE_LSB = 16;
    localparam int PTR_LIMIT_MSB = 15;
    localparam logic [31:0] WORD_STEP = 32'h4;
    localparam logic TI_GLOBAL = 1'h0;
    localparam logic TI_LOCAL = 1'h1;
    localparam logic [1:0] PRIV_MOST = 2'h0;
    localparam logic [1:0] PRIV_LEAST = 2'h3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [47:0] PTR_RESET = 48'h0;
    localparam logic [15:0] SEL_RESET = 16'h0;
    localparam logic [31:0] BASE_RESET = 32'h0;

    // ------------------------------------------------------------
    // Operating modes and commands
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_REAL = 2'h0,
        MODE_V86 = 2'h1,
        MODE_PROT = 2'h2
    } sat_mode_t;

    typedef enum logic [2:0] {
        OP_LOAD_SEG = 3'h0,
        OP_LOAD_GTP = 3'h1,
        OP_LOAD_LTS = 3'h2,
        OP_LOAD_ITP = 3'h3,
        OP_STORE_GTP = 3'h4,
        OP_STORE_LTS = 3'h5,
        OP_STORE_ITP = 3'h6
    } sat_op_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FETCH0 = 4'h2,
        ST_FETCH1 = 4'h4,
        ST_PAGE = 4'h8
    } sat_state_t;

    // Larger number means less privileged
    function automatic logic [1:0] sat_eff_priv(input logic [1:0] cpl,
                                                input logic [1:0] requested_privilege_level);
        return (requested_privilege_level > cpl) ? requested_privilege_level : cpl;
    endfunction

    // Gather the scattered base bytes of an eight-byte descriptor
    function automatic logic [31:0] sat_desc_base(input logic [31:0] w0,
                                                  input logic [31:0] w1);
        return {w1[31:24], w1[7:0], w0[31:16]};
    endfunction
endpackage

// ===== rtl/sat_sel_if.sv
// Selector decode signals between the core and its decoder
interface sat_sel_if;
    logic [15:0] selector;
    logic [1:0] cpl;
    logic [1:0] requested_privilege_level;
    logic ti;
    logic [12:0] index;
    logic nullSel;
    logic [1:0] effPriv;
    modport dec (input selector, cpl,
                 output requested_privilege_level, ti, index, nullSel, effPriv);
    modport use_side (output selector, cpl,
                      input requested_privilege_level, ti, index, nullSel, effPriv);
endinterface

// ===== rtl/sat_sel_decode.sv
// Selector field decoder
module sat_sel_decode
    import sat_pkg::*;
(
    sat_sel_if.dec sel // Selector in, fields out
);
    // ------------------------------------------------------------
    // Field split
    // ------------------------------------------------------------
    always_comb begin
        sel.requested_privilege_level = sel.selector[RPL_LSB +: 2];
        sel.ti = sel.selector[TI_BIT];
        sel.index = sel.selector[INDEX_LSB +: INDEX_W]; // [RL7] [RL10]
        // Entry 0 of the global table is never a usable segment
        sel.nullSel = (sel.selector[TI_BIT] == TI_GLOBAL) &&
                      (sel.selector[INDEX_LSB +: INDEX_W] == 13'h0);
        sel.effPriv = sat_eff_priv(sel.cpl, sel.selector[RPL_LSB +: 2]);
    end
endmodule // sat_sel_decode

// ===== rtl/sat_page_cache.sv
// Small direct-mapped cache of linear-to-physical page entries
module sat_page_cache
    import sat_pkg::*;
(
    input wire logic core_clk, // Core clock
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic fillEn, // Write one entry
    input wire logic [19:0] fillLin, // Linear page number
    input wire logic [19:0] fillPhys, // Physical page number
    input wire logic [31:0] linAddr, // Address to translate
    output logic hit, // Entry found
    output logic [31:0] physAddr // Translated address
);
    typedef struct packed {
        logic [TLB_ENTRIES-1:0] valid;
        logic [TLB_ENTRIES-1:0][TLB_TAG_W-1:0] tag;
        logic [TLB_ENTRIES-1:0][PAGE_W-1:0] frame;
    } sat_tlb_t;

    sat_tlb_t st;
    sat_tlb_t next_st;
    logic [TLB_IDX_W-1:0] look;

    // ------------------------------------------------------------
    // Fill
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (fillEn) begin
            next_st.valid[fillLin[TLB_IDX_W-1:0]] = 1'b1;
            next_st.tag[fillLin[TLB_IDX_W-1:0]] = fillLin[19:TLB_IDX_W];
            next_st.frame[fillLin[TLB_IDX_W-1:0]] = fillPhys;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Lookup, the page offset passes through untouched
    // ------------------------------------------------------------
    always_comb begin
        look = linAddr[PAGE_SHIFT +: TLB_IDX_W];
        hit = st.valid[look] &&
              (st.tag[look] == linAddr[31:PAGE_SHIFT+TLB_IDX_W]); // [RL2]
        physAddr = {st.frame[look], linAddr[PAGE_SHIFT-1:0]}; // [RL2]
    end

    fill_hits_a: assert property ( // [RL2]
        @(posedge core_clk) disable iff (!reset_n)
        fillEn && linAddr[31:PAGE_SHIFT] == fillLin |=> hit) // [RL2]
        else $error("filled page does not hit");
endmodule // sat_page_cache

// ===== rtl/segment_address_translation.sv
// Segment translation core: selector cache, table pointers, address path
// ----------------------------------------------------------------
// Overview of operation
// [RL1] V86 forms real-mode address, then pages; here V86 pages only while pagingOn is set
// [RL2] Paging maps linear to physical via cache
// [RL3] Protected linear equals segment base plus offset
// [RL4] Protected base comes from fetched table descriptor
// [RL5] Protected mode pages when enabled, else direct
// [RL6] Each segment caches selector and descriptor base
// [RL7] Selector splits into privilege, table bit, index
// [RL8] Privilege 0 most, 3 least privileged
// [RL9] Table bit 0 global, 1 local table
// [RL10] Thirteen-bit index picks the table entry
// [RL11] Tables hold 8192 eight-byte entries, 64 KB
// [RL12] Global entry 0 is the null descriptor
// [RL13] Global pointer: base 47:16, limit 15:0
// [RL14] Local selector is 16 bits, names global entry
// [RL15] Global and interrupt loads take linear base
// [RL16] Load and store global and local registers
// [RL17] Real base is segment times 16 plus offset
// [RL18] Protected sum is 32 bits, carry dropped
// ----------------------------------------------------------------
module segment_address_translation
    import sat_pkg::*;
(
    input wire logic core_clk, // Core clock, 10 MHz
    input wire logic reset_n, // Asynchronous reset, active low
    input wire sat_pkg::sat_mode_t mode, // Operating mode
    input wire logic pagingOn, // Paging enabled
    input wire logic [1:0] cpl, // Current privilege level
    input wire logic cmdValid, // Command request
    input wire sat_pkg::sat_op_t cmdOp, // Command code
    input wire logic [2:0] cmdSeg, // Segment register number
    input wire logic [47:0] cmdData, // Selector or pointer value
    input wire logic xlatValid, // Translate request
    input wire logic [2:0] xlatSeg, // Segment register used
    input wire logic [31:0] xlatOffset, // Offset address
    input wire logic memAck, // Descriptor word returned
    input wire logic [31:0] memData, // Descriptor word
    input wire logic pteWrite, // Page entry fill strobe
    input wire logic [19:0] pteLinPage, // Linear page of the fill
    input wire logic [19:0] ptePhysPage, // Physical page of the fill
    output logic ready, // Idle, may take a request
    output logic cmdDone, // Command finished pulse
    output logic cmdFault, // Load or unknown command refused at finish
    output logic [47:0] storeData, // Stored register value
    output logic memReq, // Descriptor read request
    output logic [31:0] memAddr, // Descriptor word address
    output logic xlatDone, // Translation finished pulse
    output logic [31:0] physAddr, // Resulting address
    output logic xlatFault, // Null or unusable segment
    output logic pageMiss, // Paging entry missing
    output logic [1:0] effPriv // Effective privilege of access
);
    typedef struct packed {
        sat_state_t state;
        logic [SEG_COUNT-1:0][SEL_W-1:0] segSel;
        logic [SEG_COUNT-1:0][ADDR_W-1:0] segBase;
        logic [SEG_COUNT-1:0] segUsable;
        logic [PTR_W-1:0] gtp;
        logic [PTR_W-1:0] itp;
        logic [SEL_W-1:0] lts;
        logic [ADDR_W-1:0] ldtBase;
        logic ldtOk;
        sat_op_t op;
        logic [2:0] seg;
        logic [SEL_W-1:0] pendSel;
        logic [31:0] word0;
        logic [31:0] linear;
        logic paged;
        logic ready;
        logic cmdDone;
        logic cmdFault;
        logic [47:0] storeData;
        logic memReq;
        logic [31:0] memAddr;
        logic xlatDone;
        logic [31:0] physAddr;
        logic xlatFault;
        logic pageMiss;
        logic [1:0] effPriv;
    } sat_regs_t;

    sat_regs_t st;
    sat_regs_t next_st;
    sat_sel_if selBus ();
    logic pgHit;
    logic [31:0] pgPhys;
    logic [31:0] tableBase;
    logic [31:0] descBase;
    logic [1:0] xlatRpl;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    assign selBus.selector = cmdData[SEL_W-1:0];
    assign selBus.cpl = cpl;

    sat_sel_decode u_dec (
        .sel(selBus.dec)
    );

    sat_page_cache u_page (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .fillEn(pteWrite),
        .fillLin(pteLinPage),
        .fillPhys(ptePhysPage),
        .linAddr(st.linear),
        .hit(pgHit),
        .physAddr(pgPhys)
    );

    // Table pick and descriptor address; index scaled by eight bytes,
    // so a table never reaches beyond 64 KB past its base
    always_comb begin
        tableBase = (selBus.ti == TI_LOCAL) ? st.ldtBase
                  : st.gtp[PTR_W-1:PTR_BASE_LSB]; // [RL9] [RL13]
        descBase = sat_desc_base(st.word0, memData); // [RL4]
        xlatRpl = st.segSel[xlatSeg][RPL_LSB +: 2];
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.cmdDone = 1'b0;
        next_st.xlatDone = 1'b0;
        case (st.state)
            ST_IDLE: begin
                if (cmdValid) begin
                    next_st.op = cmdOp;
                    next_st.seg = cmdSeg;
                    next_st.pendSel = cmdData[SEL_W-1:0];
                    next_st.cmdFault = 1'b0;
                    next_st.cmdDone = 1'b1;
                    case (cmdOp)
                        OP_LOAD_SEG: begin
                            if (mode != MODE_PROT) begin
                                next_st.segSel[cmdSeg] = cmdData[15:0];
                                next_st.segBase[cmdSeg] = 32'(
                                    {cmdData[15:0], 4'h0}); // [RL17]
                                next_st.segUsable[cmdSeg] = 1'b1;
                            end else if (selBus.nullSel) begin
                                // Null load is legal, but use faults
                                next_st.segSel[cmdSeg] = cmdData[15:0];
                                next_st.segUsable[cmdSeg] = 1'b0; // [RL12]
                            end else if (selBus.ti == TI_LOCAL &&
                                         !st.ldtOk) begin
                                next_st.cmdFault = 1'b1;
                            end else begin
                                next_st.cmdDone = 1'b0;
                                next_st.memReq = 1'b1;
                                next_st.memAddr = tableBase +
                                    {16'h0, selBus.index,
                                     3'h0}; // [RL7] [RL10] [RL11]
                                next_st.state = ST_FETCH0;
                            end
                        end
                        OP_LOAD_LTS: begin
                            next_st.lts = cmdData[15:0]; // [RL14] [RL16]
                            if (selBus.nullSel) begin
                                next_st.ldtOk = 1'b0; // [RL12]
                            end else if (selBus.ti == TI_LOCAL) begin
                                next_st.ldtOk = 1'b0;
                                next_st.cmdFault = 1'b1;
                            end else begin
                                // Local table descriptor lives in global
                                next_st.cmdDone = 1'b0;
                                next_st.memReq = 1'b1;
                                next_st.memAddr =
                                    st.gtp[PTR_W-1:PTR_BASE_LSB] +
                                    {16'h0, selBus.index, 3'h0}; // [RL14]
                                next_st.state = ST_FETCH0;
                            end
                        end
                        OP_LOAD_GTP: begin
                            // Base taken as linear, usable in real mode
                            next_st.gtp = cmdData; // [RL15] [RL16]
                        end
                        OP_LOAD_ITP: begin
                            next_st.itp = cmdData; // [RL15]
                        end
                        OP_STORE_GTP: begin
                            next_st.storeData = st.gtp; // [RL16]
                        end
                        OP_STORE_LTS: begin
                            next_st.storeData = {32'h0, st.lts}; // [RL16]
                        end
                        OP_STORE_ITP: begin
                            next_st.storeData = st.itp;
                        end
                        default: begin
                            next_st.cmdFault = 1'b1;
                        end
                    endcase
                end else if (xlatValid) begin
                    next_st.effPriv = sat_eff_priv(cpl, xlatRpl); // [RL8]
                    next_st.xlatFault = 1'b0;
                    if (mode == MODE_PROT) begin
                        // Cached base, 32-bit wrap
                        next_st.linear = st.segBase[xlatSeg] +
                                         xlatOffset; // [RL3] [RL6] [RL18]
                        next_st.xlatFault = !st.segUsable[xlatSeg];
                    end else begin
                        // Sum wraps at 20 bits, upper twelve stay zero
                        next_st.linear = {12'h0, REAL_ADDR_W'(
                            st.segBase[xlatSeg] +
                            {16'h0, xlatOffset[15:0]})}; // [RL17] [RL1]
                        next_st.effPriv = PRIV_LEAST;
                    end
                    // Real mode never pages
                    next_st.paged = pagingOn &&
                                    (mode != MODE_REAL); // [RL1] [RL5]
                    next_st.state = ST_PAGE;
                end
            end
            ST_FETCH0: begin
                if (memAck) begin
                    next_st.word0 = memData;
                    next_st.memAddr = st.memAddr + WORD_STEP;
                    next_st.state = ST_FETCH1;
                end
            end
            ST_FETCH1: begin
                if (memAck) begin
                    next_st.memReq = 1'b0;
                    next_st.cmdDone = 1'b1;
                    next_st.state = ST_IDLE;
                    if (st.op == OP_LOAD_LTS) begin
                        next_st.ldtBase = descBase;
                        next_st.ldtOk = 1'b1;
                    end else begin
                        next_st.segSel[st.seg] = st.pendSel; // [RL6]
                        next_st.segBase[st.seg] = descBase; // [RL4] [RL6]
                        next_st.segUsable[st.seg] = 1'b1;
                    end
                end
            end
            ST_PAGE: begin
                next_st.xlatDone = 1'b1;
                next_st.pageMiss = st.paged && !pgHit;
                next_st.physAddr = st.paged ? pgPhys
                                 : st.linear; // [RL1] [RL2] [RL5]
                next_st.state = ST_IDLE;
            end
            default: begin
                next_st.state = ST_IDLE;
                next_st.memReq = 1'b0;
            end
        endcase
        next_st.ready = (next_st.state == ST_IDLE);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.state <= ST_IDLE;
            st.op <= OP_LOAD_SEG;
            st.gtp <= PTR_RESET;
            st.itp <= PTR_RESET;
            st.lts <= SEL_RESET;
            st.ldtBase <= BASE_RESET;
            st.ready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    assign ready = st.ready;
    assign cmdDone = st.cmdDone;
    assign cmdFault = st.cmdFault;
    assign storeData = st.storeData;
    assign memReq = st.memReq;
    assign memAddr = st.memAddr;
    assign xlatDone = st.xlatDone;
    assign physAddr = st.physAddr;
    assign xlatFault = st.xlatFault;
    assign pageMiss = st.pageMiss;
    assign effPriv = st.effPriv;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    wire takeX = st.ready && !cmdValid && xlatValid;
    wire takeC = st.ready && cmdValid;

    prot_sum_a: assert property ( // [RL3]
        @(posedge core_clk) disable iff (!reset_n)
        takeX && mode == MODE_PROT |=> st.linear ==
        $past(st.segBase[xlatSeg]) + $past(xlatOffset)) // [RL3]
        else $error("protected linear sum wrong");
    real_addr_a: assert property ( // [RL17]
        @(posedge core_clk) disable iff (!reset_n)
        takeX && mode != MODE_PROT |=> st.linear[31:20] == 12'h0) // [RL17]
        else $error("real address above 20 bits");
    direct_path_a: assert property ( // [RL5]
        @(posedge core_clk)
        disable iff (!reset_n)
        takeX && !pagingOn |=> ##1 xlatDone &&
        physAddr == $past(st.linear)) // [RL5]
        else $error("unpaged address altered");
    real_nopage_a: assert property ( // [RL1]
        @(posedge core_clk)
        disable iff (!reset_n)
        takeX && mode == MODE_REAL |=> !st.paged) // [RL1]
        else $error("real mode paged");
    null_entry_a: assert property ( // [RL12]
        @(posedge core_clk)
        disable iff (!reset_n)
        takeC && cmdOp == OP_LOAD_SEG && mode == MODE_PROT &&
        selBus.nullSel |=> !memReq && !st.segUsable[$past(cmdSeg)])
        // [RL12]
        else $error("null entry fetched");
    table_pick_a: assert property ( // [RL9]
        @(posedge core_clk)
        disable iff (!reset_n)
        takeC && cmdOp == OP_LOAD_SEG && mode == MODE_PROT &&
        !selBus.nullSel && !selBus.ti |=> memReq &&
        memAddr == $past(st.gtp[47:16]) + {16'h0, $past(cmdData[15:3]),
        3'h0}) // [RL9]
        else $error("global table address wrong");
    cache_fill_a: assert property ( // [RL6]
        @(posedge core_clk)
        disable iff (!reset_n)
        st.state == ST_FETCH1 && memAck && st.op == OP_LOAD_SEG |=>
        st.segBase[$past(st.seg)] == $past(descBase) &&
        st.segSel[$past(st.seg)] == $past(st.pendSel)) // [RL6]
        else $error("segment cache not filled");
    ptr_store_a: assert property ( // [RL16]
        @(posedge core_clk) disable iff (!reset_n)
        takeC && cmdOp == OP_LOAD_GTP ##1 !cmdValid ##1 takeC &&
        cmdOp == OP_STORE_GTP |=> storeData == $past(cmdData, 3))
        else $error("pointer store mismatch");
    priv_a: assert property ( // [RL8]
        @(posedge core_clk) disable iff (!reset_n)
        takeX && mode == MODE_PROT && xlatRpl == PRIV_LEAST |=>
        effPriv == PRIV_LEAST) // [RL8]
        else $error("least privilege lost");
    done_once_a: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        xlatDone |=> !xlatDone)
        else $error("done longer than one cycle");

    fetch_c: cover property (@(posedge core_clk) disable iff (!reset_n)
        st.state == ST_FETCH1 && memAck);
    local_c: cover property (@(posedge core_clk) disable iff (!reset_n)
        takeC && cmdOp == OP_LOAD_SEG && selBus.ti);
    paged_c: cover property (@(posedge core_clk) disable iff (!reset_n)
        st.state == ST_PAGE && st.paged && pgHit);
    fault_c: cover property (@(posedge core_clk) disable iff (!reset_n)
        xlatDone && xlatFault);
endmodule // segment_address_translation

// ===== testbench/testbench.sv
// Self-checking bench for the segment address translation block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sat_pkg::*;
    logic core_clk = 0, reset_n = 0, pagingOn = 0, cmdValid = 0;
    logic xlatValid = 0, memAck = 0, pteWrite = 0;
    sat_mode_t mode = MODE_REAL;
    sat_op_t cmdOp = OP_LOAD_SEG;
    logic [1:0] cpl = 2'h0;
    logic [2:0] cmdSeg = 3'h0, xlatSeg = 3'h0;
    logic [47:0] cmdData = 48'h0;
    logic [31:0] xlatOffset = 32'h0, memData = 32'h0;
    logic [31:0] w0 = 32'h0, w1 = 32'h0, expAddr = 32'h0;
    logic [19:0] pteLinPage = 20'h0, ptePhysPage = 20'h0;
    logic ready, cmdDone, cmdFault, memReq, xlatDone, xlatFault, pageMiss;
    logic [47:0] storeData;
    logic [31:0] memAddr, physAddr;
    logic [1:0] effPriv;
    int bad_count = 0, n_compared = 0, cycles = 0;

    segment_address_translation u_dut (
        .core_clk(core_clk), .reset_n(reset_n), .mode(mode),
        .pagingOn(pagingOn), .cpl(cpl), .cmdValid(cmdValid), .cmdOp(cmdOp),
        .cmdSeg(cmdSeg), .cmdData(cmdData), .xlatValid(xlatValid),
        .xlatSeg(xlatSeg), .xlatOffset(xlatOffset), .memAck(memAck),
        .memData(memData), .pteWrite(pteWrite), .pteLinPage(pteLinPage),
        .ptePhysPage(ptePhysPage), .ready(ready), .cmdDone(cmdDone),
        .cmdFault(cmdFault), .storeData(storeData), .memReq(memReq),
        .memAddr(memAddr), .xlatDone(xlatDone), .physAddr(physAddr),
        .xlatFault(xlatFault), .pageMiss(pageMiss), .effPriv(effPriv)
    );

    // 10 MHz core clock; the cycle ceiling cuts a hang short
    initial forever #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Command, answering descriptor reads word by word as the fetch asks
    task automatic cmd(input sat_op_t op, input logic [2:0] seg,
                       input logic [47:0] d);
        @(negedge core_clk);
        cmdOp = op;
        cmdSeg = seg;
        cmdData = d;
        cmdValid = 1;
        @(negedge core_clk);
        cmdValid = 0;
        for (int i = 0; i < 20 && cmdDone !== 1'b1; i++) begin
            if (memReq === 1'b1) begin
                chk(memAddr, expAddr);
                expAddr += 32'h4;
            end
            memAck = memReq;
            memData = memAddr[2] ? w1 : w0;
            @(negedge core_clk);
        end
        memAck = 0;
        chk(cmdDone, 1'b1);
    endtask

    // Translation answers exactly one rising edge after it is taken
    task automatic xlat(input logic [2:0] seg, input logic [31:0] off);
        @(negedge core_clk);
        xlatSeg = seg;
        xlatOffset = off;
        xlatValid = 1;
        @(negedge core_clk);
        xlatValid = 0;
        chk(ready, 1'b0);
        @(negedge core_clk);
        chk(xlatDone, 1'b1);
    endtask

    task automatic fill(input logic [19:0] lin, input logic [19:0] phys);
        @(negedge core_clk);
        pteLinPage = lin;
        ptePhysPage = phys;
        pteWrite = 1;
        @(negedge core_clk);
        pteWrite = 0;
    endtask

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence: pointers, real and v86 paths, then protected mode
    initial begin
        repeat (20) @(negedge core_clk);
        reset_n = 1;
        cmd(OP_STORE_GTP, 3'h0, 48'h0);
        chk(storeData, PTR_RESET);
        cmd(OP_LOAD_GTP, 3'h0, 48'h0000_1000_00ff);
        cmd(OP_STORE_GTP, 3'h0, 48'h0);
        chk(storeData, 48'h0000_1000_00ff);
        cmd(OP_LOAD_ITP, 3'h0, 48'habcd_0123_07ff);
        cmd(OP_STORE_ITP, 3'h0, 48'h0);
        chk(storeData, 48'habcd_0123_07ff);
        cmd(OP_STORE_LTS, 3'h0, 48'h0);
        chk(storeData, 48'h0);
        cmd(sat_op_t'(3'h7), 3'h0, 48'h0);
        chk(cmdFault, 1'b1);
        $display("test pointers done");
        cmd(OP_LOAD_SEG, 3'h1, 48'h1234);
        xlat(3'h1, 32'h5678);
        chk(physAddr, 32'h0001_79b8);
        fill(20'h00017, 20'h00abc);
        pagingOn = 1;
        xlat(3'h1, 32'h5678);
        chk(physAddr, 32'h0001_79b8);
        mode = MODE_V86;
        xlat(3'h1, 32'h5678);
        chk(physAddr, 32'h00ab_c9b8);
        pagingOn = 0;
        $display("test real and v86 done");
        mode = MODE_PROT;
        cpl = 2'h1;
        w0 = 32'h5678_0000;
        w1 = 32'h1200_0034;
        expAddr = 32'h0000_1010;
        cmd(OP_LOAD_SEG, 3'h2, 48'h0013);
        xlat(3'h2, 32'h10);
        chk(physAddr, 32'h1234_5688);
        chk(effPriv, 2'h3);
        w0 = 32'hf000_0000;
        w1 = 32'hff00_00ff;
        expAddr = 32'h0000_1018;
        cmd(OP_LOAD_SEG, 3'h3, 48'h0018);
        xlat(3'h3, 32'h2000);
        chk(physAddr, 32'h0000_1000);
        chk(effPriv, 2'h1);
        fill(20'h00001, 20'h55555);
        pagingOn = 1;
        xlat(3'h3, 32'h2000);
        chk(physAddr, 32'h5555_5000);
        chk(pageMiss, 1'b0);
        xlat(3'h3, 32'h3000);
        chk(pageMiss, 1'b1);
        pagingOn = 0;
        cmd(OP_LOAD_SEG, 3'h4, 48'h0003);
        xlat(3'h4, 32'h0);
        chk(xlatFault, 1'b1);
        cmd(OP_LOAD_SEG, 3'h5, 48'h0004);
        chk(cmdFault, 1'b1);
        w0 = 32'h0;
        w1 = 32'h0000_0002;
        expAddr = 32'h0000_1020;
        cmd(OP_LOAD_LTS, 3'h0, 48'h0020);
        chk(cmdFault, 1'b0);
        cmd(OP_STORE_LTS, 3'h0, 48'h0);
        chk(storeData, 48'h0020);
        w0 = 32'h0100_0000;
        w1 = 32'h0;
        expAddr = 32'h0002_0008;
        cmd(OP_LOAD_SEG, 3'h5, 48'h000c);
        xlat(3'h5, 32'h1);
        chk(physAddr, 32'h0000_0101);
        $display("test protected done");
        end_sim();
    end
endmodule // testbench
